/* logic/ser_regs.svh */
// Constants for the serial EEPROM read engine
`ifndef SER_REGS_SVH
`define SER_REGS_SVH
`define SER_ADDR_W 11
`define SER_DEPTH 2048
`define SER_BLANK_BYTE 8'hff
`define SER_RW_BIT 0
`define SER_UPPER_MSB 3
`define SER_UPPER_LSB 1
`define SER_TYPE_MSB 7
`define SER_TYPE_LSB 4
`define SER_RX_BITS 4'h8
`define SER_TX_LAST 4'h7
`endif

/* logic/ser_pkg.sv */
// Types of the serial EEPROM read engine
`default_nettype none
package ser_pkg;
    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_DEV      = 9'h002,
        ST_ACK_DEV  = 9'h004,
        ST_WORD     = 9'h008,
        ST_ACK_WORD = 9'h010,
        ST_WDAT     = 9'h020,
        ST_ACK_WDAT = 9'h040,
        ST_RD       = 9'h080,
        ST_RDACK    = 9'h100
    } ser_state_type;
endpackage
`default_nettype wire

/* logic/ser_mem_if.sv */
// Array access path between engine and storage
`timescale 1ns/1ps
`default_nettype none
`include "ser_regs.svh"
interface ser_mem_if;
    logic [`SER_ADDR_W-1:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_en;
    logic [`SER_ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    modport core (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
    modport mem (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface
`default_nettype wire

/* logic/ser_mem.sv */
// Byte array with blank-state tracking
`timescale 1ns/1ps
`default_nettype none
`include "ser_regs.svh"
module ser_mem (
    input wire logic clk,
    input wire logic rst_b,
    ser_mem_if.mem mp
);
    logic [7:0] mem_q [0:`SER_DEPTH-1];
    logic [`SER_DEPTH-1:0] written_q;

    always_ff @(posedge clk) begin
        if (mp.wr_en) begin
            mem_q[mp.wr_addr] <= mp.wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            written_q <= '0;
        end else if (mp.wr_en) begin
            written_q[mp.wr_addr] <= 1'b1;
        end
    end

    // Unwritten locations read blank
    assign mp.rd_data = written_q[mp.rd_addr] ? mem_q[mp.rd_addr] : `SER_BLANK_BYTE; // RULE_10

    AST_BLANK_READ: assert property (@(posedge clk) disable iff (!rst_b) // RULE_10
        !written_q[mp.rd_addr] |-> mp.rd_data == `SER_BLANK_BYTE)
        else $error("Unwritten location did not read blank");
    AST_WRITE_MARKS: assert property (@(posedge clk) disable iff (!rst_b) // RULE_10
        mp.wr_en |=> written_q[$past(mp.wr_addr)])
        else $error("Written location still marked blank");
endmodule
`default_nettype wire

/* logic/ser_eeprom_read.sv */
// Two-wire EEPROM target engine with sequential read
`timescale 1ns/1ps
`default_nettype none
`include "ser_regs.svh"
// Notes on behaviour
// (RULE_01) Address counter holds last accessed address plus one between operations; after a write byte the code advances only bits 3..0, wrapping within them.
// (RULE_02) Reading past the last byte wraps the counter to address zero.
// (RULE_03) Read device byte is acked, then byte at counter is shifted out.
// (RULE_04) Master no-ack after a data byte releases data line and goes idle.
// (RULE_05) Master follows its no-ack with Stop or a new Start.
// (RULE_06) Random read starts with a write header and word address only.
// (RULE_07) After dummy write acks, master sends repeated Start and read header.
// (RULE_08) Read header upper address bits are ignored; counter stays as loaded.
// (RULE_09) Each master ack increments the address and shifts the next byte.
// (RULE_10) Never written locations read as FFh.
// (RULE_11) Header bits 3..1 carry upper address bits; bit 0 selects direction.
// (RULE_12) Word address byte holds the low eight address bits, MSB first.
// (RULE_13) Header with a foreign type code is not acked; engine goes idle.
// (RULE_14) Data leaves MSB first, one bit per clock, changing while clock low.
module ser_eeprom_read #(
    parameter logic [3:0] TYPE_CODE = 4'h5 // Arbitrary type code
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE
);
    ser_mem_if mif ();
    ser_mem u_mem (.clk(CLOCK), .rst_b(RST_B), .mp(mif.mem));

    logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
    logic scl_rise, scl_fall, start_cond, stop_cond, rx_done, rd_done, match, rx_state;
    ser_pkg::ser_state_type state_q, state_d;
    logic [3:0] cnt_q;
    logic [7:0] rx_q, tx_q;
    logic [`SER_ADDR_W-1:0] addr_q;
    logic [2:0] upper_q;
    logic ack_q, oe_q;

    // Pin synchronisers
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= SCL_IN;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= SDA_IN;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    assign scl_rise = scl_s2_q & ~scl_s3_q;
    assign scl_fall = ~scl_s2_q & scl_s3_q;
    assign start_cond = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign stop_cond = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
    assign rx_done = scl_fall && cnt_q == `SER_RX_BITS;
    assign rd_done = scl_fall && cnt_q == `SER_TX_LAST;
    assign match = rx_q[`SER_TYPE_MSB:`SER_TYPE_LSB] == TYPE_CODE;
    assign rx_state = state_q == ser_pkg::ST_DEV || state_q == ser_pkg::ST_WORD || state_q == ser_pkg::ST_WDAT;

    // Protocol sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ser_pkg::ST_IDLE: state_d = ser_pkg::ST_IDLE;
            ser_pkg::ST_DEV: begin
                if (rx_done) begin
                    state_d = match ? ser_pkg::ST_ACK_DEV : ser_pkg::ST_IDLE; // RULE_13
                end
            end
            ser_pkg::ST_ACK_DEV: begin
                if (scl_fall) begin
                    state_d = rx_q[`SER_RW_BIT] ? ser_pkg::ST_RD : ser_pkg::ST_WORD; // RULE_11
                end
            end
            ser_pkg::ST_WORD: begin
                if (rx_done) begin
                    state_d = ser_pkg::ST_ACK_WORD;
                end
            end
            ser_pkg::ST_ACK_WORD: begin
                if (scl_fall) begin
                    state_d = ser_pkg::ST_WDAT;
                end
            end
            ser_pkg::ST_WDAT: begin
                if (rx_done) begin
                    state_d = ser_pkg::ST_ACK_WDAT;
                end
            end
            ser_pkg::ST_ACK_WDAT: begin
                if (scl_fall) begin
                    state_d = ser_pkg::ST_WDAT;
                end
            end
            ser_pkg::ST_RD: begin
                if (rd_done) begin
                    state_d = ser_pkg::ST_RDACK;
                end
            end
            ser_pkg::ST_RDACK: begin
                if (scl_fall) begin
                    state_d = ack_q ? ser_pkg::ST_RD : ser_pkg::ST_IDLE; // RULE_04 RULE_09
                end
            end
            default: state_d = ser_pkg::ST_IDLE;
        endcase
        if (stop_cond) begin
            state_d = ser_pkg::ST_IDLE;
        end
        if (start_cond) begin
            state_d = ser_pkg::ST_DEV;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= ser_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Bit counter
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            cnt_q <= 4'h0;
        end else if (start_cond || state_d != state_q) begin
            cnt_q <= 4'h0;
        end else if ((rx_state && scl_rise) || (state_q == ser_pkg::ST_RD && scl_fall)) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Receive shifter, MSB first
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rx_q <= 8'h00;
        end else if (rx_state && scl_rise) begin
            rx_q <= {rx_q[6:0], sda_s2_q}; // RULE_12
        end
    end

    // Master acknowledge sample
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ack_q <= 1'b0;
        end else if (state_q == ser_pkg::ST_RDACK && scl_rise) begin
            ack_q <= ~sda_s2_q;
        end
    end

    // Upper address bits from a write header only
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            upper_q <= 3'h0;
        end else if (state_q == ser_pkg::ST_DEV && rx_done && match && !rx_q[`SER_RW_BIT]) begin
            upper_q <= rx_q[`SER_UPPER_MSB:`SER_UPPER_LSB]; // RULE_11 RULE_08
        end
    end

    // Word address counter
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            addr_q <= '0;
        end else if (state_q == ser_pkg::ST_WORD && rx_done) begin
            addr_q <= {upper_q, rx_q}; // RULE_12
        end else if (state_q == ser_pkg::ST_WDAT && rx_done) begin
            addr_q <= {addr_q[`SER_ADDR_W-1:4], addr_q[3:0] + 4'h1}; // RULE_01
        end else if (state_q == ser_pkg::ST_RD && rd_done) begin
            addr_q <= addr_q + 11'h001; // RULE_01 RULE_02
        end
    end

    assign mif.rd_addr = addr_q;
    assign mif.wr_en = state_q == ser_pkg::ST_WDAT && rx_done;
    assign mif.wr_addr = addr_q;
    assign mif.wr_data = rx_q;

    // Data line drive, changes on clock fall; a Start or Stop releases it
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            oe_q <= 1'b0;
            tx_q <= 8'h00;
        end else if (start_cond || stop_cond) begin
            oe_q <= 1'b0;
        end else if (scl_fall) begin
            case (state_q)
                ser_pkg::ST_DEV, ser_pkg::ST_WORD, ser_pkg::ST_WDAT: oe_q <= rx_done && (match || state_q != ser_pkg::ST_DEV); // RULE_13
                ser_pkg::ST_ACK_DEV: begin
                    if (rx_q[`SER_RW_BIT]) begin
                        oe_q <= ~mif.rd_data[7]; // RULE_03 RULE_14
                        tx_q <= {mif.rd_data[6:0], 1'b0};
                    end else begin
                        oe_q <= 1'b0;
                    end
                end
                ser_pkg::ST_RD: begin
                    oe_q <= rd_done ? 1'b0 : ~tx_q[7]; // RULE_14
                    tx_q <= {tx_q[6:0], 1'b0};
                end
                ser_pkg::ST_RDACK: begin
                    oe_q <= ack_q & ~mif.rd_data[7]; // RULE_09 RULE_04
                    tx_q <= {mif.rd_data[6:0], 1'b0};
                end
                default: oe_q <= 1'b0;
            endcase
        end
    end

    assign SDA_OE = oe_q;
    assign SDA_OUT = 1'b0;

    sequence s_hdr_done;
        state_q == ser_pkg::ST_DEV && rx_done;
    endsequence

    sequence s_read_hdr_acked;
        s_hdr_done ##0 (match && rx_q[`SER_RW_BIT]);
    endsequence

    AST_READ_HDR_ACK: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_03
        s_read_hdr_acked |=> oe_q && state_q == ser_pkg::ST_ACK_DEV)
        else $error("Read header not acknowledged");
    AST_READ_ADDR_KEPT: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_08
        s_read_hdr_acked |=> addr_q == $past(addr_q) && upper_q == $past(upper_q))
        else $error("Read header altered the address");
    AST_FOREIGN_HDR: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_13
        s_hdr_done ##0 !match |=> state_q == ser_pkg::ST_IDLE && !oe_q)
        else $error("Foreign header was acknowledged");
    AST_UPPER_LOAD: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_11
        s_hdr_done ##0 (match && !rx_q[`SER_RW_BIT]) |=> upper_q == $past(rx_q[3:1]))
        else $error("Upper address bits not captured");
    AST_WORD_LOAD: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_12
        state_q == ser_pkg::ST_WORD && rx_done |=> addr_q == {$past(upper_q), $past(rx_q)})
        else $error("Word address not loaded");
    AST_READ_INC: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_01
        state_q == ser_pkg::ST_RD && rd_done |=> addr_q == $past(addr_q) + 11'h001)
        else $error("Counter did not advance after a read byte");
    AST_READ_WRAP: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_02
        state_q == ser_pkg::ST_RD && rd_done && addr_q == 11'h7ff |=> addr_q == 11'h000)
        else $error("Counter did not wrap to zero");
    AST_NACK_IDLE: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_04
        state_q == ser_pkg::ST_RDACK && scl_fall && !ack_q && !start_cond |=> state_q == ser_pkg::ST_IDLE && !oe_q)
        else $error("No-ack did not end the read");
    AST_ACK_NEXT: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_09
        state_q == ser_pkg::ST_RDACK && scl_fall && ack_q && !start_cond && !stop_cond
        |=> state_q == ser_pkg::ST_RD && oe_q == ~$past(mif.rd_data[7]))
        else $error("Ack did not start the next byte");
    AST_DRIVE_CLOCK_LOW: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_14
        state_q == ser_pkg::ST_RD && $past(state_q) == ser_pkg::ST_RD && $changed(oe_q) |-> !scl_s3_q)
        else $error("Data changed while clock high");
endmodule
`default_nettype wire

/* test/ser_master_model.sv */
// Two-wire bus master model for the read engine bench
`timescale 1ns/1ps
`default_nettype none
module ser_master_model #(
    parameter logic [3:0] TYPE_CODE = 4'h5 // Arbitrary type code
) (
    input wire logic clk,
    input wire logic dev_oe,
    output logic scl,
    output logic sda_pull
);
    wire logic sda_w;
    assign sda_w = ~(sda_pull | dev_oe);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic low_phase();
        scl <= 1'b0;
        tick(4);
    endtask
    task automatic send_bit(input logic b);
        low_phase();
        sda_pull <= ~b;
        tick(2);
        scl <= 1'b1;
        tick(6);
    endtask
    task automatic recv_bit(output logic b);
        low_phase();
        sda_pull <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(3);
        b = sda_w;
        tick(3);
    endtask
    // Start or repeated Start from any bus state
    task automatic start_cond();
        low_phase();
        sda_pull <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(6);
        sda_pull <= 1'b1;
        tick(6);
    endtask
    task automatic stop_cond();
        low_phase();
        sda_pull <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(6);
        sda_pull <= 1'b0;
        tick(6);
    endtask
    task automatic write_byte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            send_bit(v[i]);
        end
        recv_bit(b);
        ack = ~b;
    endtask
    // Ninth clock carries ack or no-ack; the caller follows a no-ack with Stop or Start
    task automatic read_byte(input logic ack, output logic [7:0] v);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            recv_bit(b);
            v[i] = b;
        end
        send_bit(~ack);
    endtask
    task automatic header(input logic [2:0] upper, input logic rd, output logic ack);
        start_cond();
        write_byte({TYPE_CODE, upper, rd}, ack);
    endtask
    // Dummy write with no data and no Stop, then repeated Start
    task automatic random_start(input logic [10:0] addr, input logic [2:0] junk, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        header(addr[10:8], 1'b0, a0);
        write_byte(addr[7:0], a1);
        header(junk, 1'b1, a2);
        ok = a0 & a1 & a2;
    endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the two-wire EEPROM read engine
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [3:0] TYPE = 4'h9; // Arbitrary type code
    logic clock = 1'b0;
    logic rst_b;
    wire logic scl;
    wire logic pull;
    wire logic sda_oe;
    wire logic sda_out;
    wire logic sda_wire;
    wire logic dev_low;
    int fails = 0;
    int checked = 0;
    logic a;
    logic [7:0] d;
    // Open-drain: device pulls low only when enabled and driving zero
    assign dev_low = sda_oe & ~sda_out;
    assign sda_wire = ~(pull | dev_low);
    ser_eeprom_read #(.TYPE_CODE(TYPE)) DUT (.CLOCK(clock), .RST_B(rst_b), .SCL_IN(scl),
        .SDA_IN(sda_wire), .SDA_OUT(sda_out), .SDA_OE(sda_oe));
    ser_master_model #(.TYPE_CODE(TYPE)) m (.clk(clock), .dev_oe(dev_low), .scl(scl), .sda_pull(pull));
    always #50 clock = ~clock;
    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic results();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic t_blank();
        m.header(3'h0, 1'b1, a);
        chk_bit("hdr_ack", 1'b1, a);
        chk_bit("drive_level", 1'b0, sda_out);
        m.read_byte(1'b1, d);
        chk_byte("blank_0", 8'hff, d);
        m.read_byte(1'b0, d);
        chk_byte("blank_1", 8'hff, d);
        m.stop_cond();
        $display("test blank done");
    endtask
    task automatic wr(input logic [10:0] addr, input logic [7:0] b0, input logic [7:0] b1);
        logic a0;
        logic a1;
        logic a2;
        logic a3;
        m.header(addr[10:8], 1'b0, a0);
        m.write_byte(addr[7:0], a1);
        m.write_byte(b0, a2);
        m.write_byte(b1, a3);
        m.stop_cond();
        chk_bit("write_acks", 1'b1, a0 & a1 & a2 & a3);
    endtask
    task automatic t_random();
        wr(11'h7fe, 8'h1d, 8'hb4);
        wr(11'h000, 8'h96, 8'h69);
        m.random_start(11'h7fe, 3'h3, a);
        chk_bit("rand_ack", 1'b1, a);
        m.read_byte(1'b1, d);
        chk_byte("rand_0", 8'h1d, d);
        m.read_byte(1'b1, d);
        chk_byte("rand_1", 8'hb4, d);
        m.read_byte(1'b0, d);
        chk_byte("wrap", 8'h96, d);
        m.low_phase();
        chk_bit("released", 1'b0, sda_oe);
        m.stop_cond();
        $display("test random done");
    endtask
    task automatic t_current();
        m.header(3'h6, 1'b1, a);
        chk_bit("cur_ack", 1'b1, a);
        m.read_byte(1'b0, d);
        chk_byte("counter", 8'h69, d);
        m.start_cond();
        m.write_byte({~TYPE, 3'h0, 1'b1}, a);
        chk_bit("foreign_ack", 1'b0, a);
        m.low_phase();
        chk_bit("foreign_idle", 1'b0, sda_oe);
        m.stop_cond();
        m.header(3'h0, 1'b1, a);
        m.read_byte(1'b0, d);
        chk_byte("after_foreign", 8'hff, d);
        m.stop_cond();
        $display("test current done");
    endtask
    initial begin
        rst_b = 1'b0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        t_blank();
        t_random();
        t_current();
        results();
    end
    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        results();
    end
endmodule
`default_nettype wire
